// ===== tsi_bus_model.sv
// upstream byte bus model: one framed byte per ten clocks
`timescale 1ns/1ps
`default_nettype none
module tsi_bus_model #(
    parameter FRAME_BYTES = 20,
    parameter J1_POS      = 1    // j1 octet: one c1 octet, offset 0
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // scenario controls
    input  wire logic       transport, // parity leaves out flags
    input  wire logic [5:0] mfLen,     // frames per multiframe
    input  wire logic       noPulse,   // hold pulse back
    input  wire logic       badReq,    // spoil one parity bit
    input  wire logic       flagsIn,   // tributary flags level
    input  wire logic [9:0] rndIn,     // random byte and flags
    // incoming byte bus
    output logic            framePulse,
    output logic [7:0]      busByte,
    output logic            parity,
    output logic            payloadFlag,
    output logic            payloadInd,
    output logic            tribPayload,
    output logic            tribAlarm
);
    logic [3:0] slot_reg;  // clock within byte slot
    int         byte_reg;  // octet within frame
    int         frame_reg; // frame within multiframe
    logic       bad_reg;   // spoil pending
    // change mid-slot so the byte is steady when sampled
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_reg <= 4'h0;
            byte_reg <= 0;
            frame_reg <= 0;
            bad_reg <= 1'b0;
            {framePulse, busByte, parity, payloadFlag} <= '0;
            {payloadInd, tribPayload, tribAlarm} <= '0;
        end else begin
            slot_reg <= (slot_reg == 4'h9) ? 4'h0 : slot_reg + 4'h1;
            if (slot_reg == 4'h4) begin
                busByte <= rndIn[7:0];
                // transport: c1 overhead octet low, payload high
                payloadFlag <= transport ? byte_reg != 0
                                         : rndIn[8];
                payloadInd <= rndIn[9];
                // c1 pulse on frame 0; in transport also every j1, and on frame 0 the byte after
                framePulse <= !noPulse
                    && ((byte_reg == 0 && frame_reg == 0)
                    || (transport && byte_reg == J1_POS)
                    || (transport && byte_reg == J1_POS + 1
                        && frame_reg == 0));
                parity <= ^rndIn[7:0] ^ bad_reg
                        ^ (!transport && ^rndIn[9:8]);
                tribPayload <= flagsIn;
                tribAlarm <= flagsIn;
                bad_reg <= 1'b0;
                byte_reg <= (byte_reg == FRAME_BYTES - 1) ? 0 : byte_reg + 1;
                if (byte_reg == FRAME_BYTES - 1) begin
                    frame_reg <= (frame_reg + 1 >= mfLen) ? 0 : frame_reg + 1;
                end
            end
            if (badReq) begin
                bad_reg <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tsi_defs.vh
// constants for the tdm bus to serial ingress block
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH

// register byte offsets on the wishbone port
`define TSI_ADDR_W      8
`define TSI_ADDR_CTRL   8'h00
`define TSI_ADDR_STAT   8'h04
`define TSI_ADDR_PCNT   8'h08

// control register fields
`define TSI_CTRL_W      6
`define TSI_CTRL_RST    6'h00
`define TSI_CTRL_TPORT  0
`define TSI_CTRL_CAS    1
`define TSI_CTRL_ODD    2
`define TSI_CTRL_PFP    3
`define TSI_CTRL_PPL    4
`define TSI_CTRL_J1SEL  5

// status register fields
`define TSI_ST_LOCK     0
`define TSI_ST_FLY      1
`define TSI_ST_PERR     2
`define TSI_ST_MISAL    3
`define TSI_ST_ALARM    4
`define TSI_ST_TPL      5
`define TSI_STICKY_RST  4'h0

// framing figures
`define TSI_MF_TRIB     6'd4
`define TSI_MF_CAS      6'd48
`define TSI_J1_OFS_A    14'd0
`define TSI_J1_OFS_B    14'd522

// line rate over byte rate gives bits per character
`define TSI_LINE_KBPS   777600
`define TSI_BYTE_KHZ    77760
`define TSI_BITS_CHAR   (`TSI_LINE_KBPS / `TSI_BYTE_KHZ)

// comma character halves and code balance
`define TSI_K28_6B      6'h0F
`define TSI_K28_4B      4'h5
`define TSI_BAL6        3'd3
`define TSI_BAL4        3'd2
`define TSI_PCNT_W      16

`endif

// ===== tsi_ingress.v
// ingress byte bus sampler, aligner and dual 8b/10b serial transmitter
//
// Overview of operation
// R1 - upstream pulses frame pulse on first C1
// R2 - tributary mode: pulse every fourth C1 octet
// R3 - flywheel alignment when frame pulse absent
// R4 - with signaling, pulse on 48-frame boundaries
// R5 - transport: J1 pulses, offset 0 or 522
// R6 - pulse after J1 marks multiframe, V1 frame
// R7 - sample all bus inputs on reference clock
// R8 - bus columns driven by unique upstream sources
// R9 - parity covers data and mode-dependent flags
// R10 - payload flag marks tributary octets, justification
// R11 - fractional links: flag only valid octets
// R12 - locked tributaries drive flag as floating
// R13 - locked tributaries: indicator floating or low
// R14 - indicator moves with matching flag adjustment
// R15 - transport: flag high payload, low overhead
// R16 - transport: indicator marks V5 bytes
// R17 - tributary payload used only in transport
// R18 - tributary alarm used only in transport
// R19 - 8b/10b encode, bit a sent first
// R20 - ten line bits per bus byte
// R21 - transmit pulse when C1 character sent
// R22 - transmit pulse every 4 or 48 frames
// R23 - system clock is the master clock
// R24 - reference clock tied to system clock
// R25 - parity mismatch reported to software
// R26 - working and protect links carry same
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"

module tsi_ingress #(
    parameter FRAME_BYTES = 9720,   // octets per frame
    parameter C1_OCTETS   = 1,      // c1 octets ahead of j1
    parameter BCW         = 14      // frame octet counter width
) (
    // system clock and reset
    input  wire        clk,
    input  wire        rst,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg         wb_ack_o,
    output reg  [31:0] wb_dat_o,
    // incoming byte bus
    input  wire        incomingFramePulse,
    input  wire [7:0]  incomingBusByte,
    input  wire        incomingParity,
    input  wire        incomingPayloadFlag,
    input  wire        incomingPayloadIndicator,
    input  wire        incomingTributaryPayload,
    input  wire        incomingTributaryAlarm,
    // serial links and transmit frame pulse
    output reg         txWorkP,
    output reg         txWorkN,
    output reg         txProtP,
    output reg         txProtN,
    output reg         txFramePulse
);

    // 5b/6b code for negative running disparity, bit a in msb
    function [5:0] tsi_enc6;
        input [4:0] x;
        begin
            case (x)
                5'h00: tsi_enc6 = 6'h27;
                5'h01: tsi_enc6 = 6'h1D;
                5'h02: tsi_enc6 = 6'h2D;
                5'h03: tsi_enc6 = 6'h31;
                5'h04: tsi_enc6 = 6'h35;
                5'h05: tsi_enc6 = 6'h29;
                5'h06: tsi_enc6 = 6'h19;
                5'h07: tsi_enc6 = 6'h38;
                5'h08: tsi_enc6 = 6'h39;
                5'h09: tsi_enc6 = 6'h25;
                5'h0A: tsi_enc6 = 6'h15;
                5'h0B: tsi_enc6 = 6'h34;
                5'h0C: tsi_enc6 = 6'h0D;
                5'h0D: tsi_enc6 = 6'h2C;
                5'h0E: tsi_enc6 = 6'h1C;
                5'h0F: tsi_enc6 = 6'h17;
                5'h10: tsi_enc6 = 6'h1B;
                5'h11: tsi_enc6 = 6'h23;
                5'h12: tsi_enc6 = 6'h13;
                5'h13: tsi_enc6 = 6'h32;
                5'h14: tsi_enc6 = 6'h0B;
                5'h15: tsi_enc6 = 6'h2A;
                5'h16: tsi_enc6 = 6'h1A;
                5'h17: tsi_enc6 = 6'h3A;
                5'h18: tsi_enc6 = 6'h33;
                5'h19: tsi_enc6 = 6'h26;
                5'h1A: tsi_enc6 = 6'h16;
                5'h1B: tsi_enc6 = 6'h36;
                5'h1C: tsi_enc6 = 6'h0E;
                5'h1D: tsi_enc6 = 6'h2E;
                5'h1E: tsi_enc6 = 6'h1E;
                default: tsi_enc6 = 6'h2B;
            endcase
        end
    endfunction

    // 3b/4b code for negative running disparity, bit f in msb
    function [3:0] tsi_enc4;
        input [2:0] y;
        begin
            case (y)
                3'h0: tsi_enc4 = 4'hB;
                3'h1: tsi_enc4 = 4'h9;
                3'h2: tsi_enc4 = 4'h5;
                3'h3: tsi_enc4 = 4'hC;
                3'h4: tsi_enc4 = 4'hD;
                3'h5: tsi_enc4 = 4'hA;
                3'h6: tsi_enc4 = 4'h6;
                default: tsi_enc4 = 4'hE;
            endcase
        end
    endfunction

    // count of ones in a sub-block
    function [2:0] tsi_ones;
        input [5:0] v;
        begin
            tsi_ones = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
                     + {2'b00, v[3]} + {2'b00, v[4]} + {2'b00, v[5]};
        end
    endfunction

    localparam integer   BITS_CHAR = `TSI_BITS_CHAR; // line bits per byte
    localparam [3:0]     BITS_LAST = BITS_CHAR[3:0] - 4'd1;
    localparam [BCW-1:0] BYTE_LAST = FRAME_BYTES[BCW-1:0] - 1'b1;
    localparam [BCW-1:0] J1_BASE   = C1_OCTETS[BCW-1:0];

    reg  [13:0] sync1Reg;              // first synchroniser stage
    reg  [13:0] sync2Reg;              // second synchroniser stage
    reg  [3:0]  divReg;                // bit slot within a character
    reg  [`TSI_CTRL_W-1:0] ctrlReg;    // software mode controls
    reg  [3:0]  stickyReg;             // perr, misal, alarm, tpl
    reg         lockReg;               // a frame pulse was seen
    reg         flyReg;                // last boundary had no pulse
    reg  [`TSI_PCNT_W-1:0] pcntReg;    // parity error tally
    reg  [BCW-1:0] byteReg;            // octet index of next byte
    reg  [5:0]  frameReg;              // frame index of next byte
    reg         rdReg;                 // running disparity, 1 = plus
    reg  [9:0]  shiftReg;              // character being serialised
    reg         kPendReg;              // shifted char is multiframe c1

    wire       fpS   = sync2Reg[13];
    wire [7:0] datS  = sync2Reg[12:5];
    wire       parS  = sync2Reg[4];
    wire       plS   = sync2Reg[3];
    wire       v5S   = sync2Reg[2];
    wire       tplS  = sync2Reg[1];
    wire       aisS  = sync2Reg[0];
    wire       tport = ctrlReg[`TSI_CTRL_TPORT];
    wire       byteEn = (divReg == BITS_LAST);
    wire       wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wbWr   = wbReq & wb_we_i & wb_sel_i[0];

    reg  [BCW-1:0] j1Pos;              // j1 octet index in frame
    reg  [5:0]  mfLast;                // last frame of multiframe
    reg         fpC1;                  // pulse taken as c1 marker
    reg         fpMf;                  // pulse after j1 in transport
    reg  [BCW-1:0] curByte;            // octet index of this byte
    reg  [5:0]  curFrame;              // frame index of this byte
    reg         parErr;                // parity mismatch this byte
    reg         misal;                 // pulse off expected octet
    reg         kChar;                 // send comma for this byte

    // frame pulse decode and position of the current byte
    always @* begin
        j1Pos = J1_BASE + (ctrlReg[`TSI_CTRL_J1SEL] ?
                `TSI_J1_OFS_B : `TSI_J1_OFS_A);           // R5
        mfLast = (tport | ~ctrlReg[`TSI_CTRL_CAS]) ?
                 `TSI_MF_TRIB - 6'd1 : `TSI_MF_CAS - 6'd1; // R22
        fpMf = tport & fpS & lockReg
             & (byteReg == j1Pos + 1'b1);                 // R6
        fpC1 = fpS & ~(tport & lockReg & ((byteReg == j1Pos)
             | (byteReg == j1Pos + 1'b1)));               // R1
        curByte  = fpC1 ? {BCW{1'b0}} : byteReg;          // R3
        curFrame = frameReg;
        if (fpMf | (fpC1 & ~tport)) begin
            curFrame = 6'd0;                              // R2 R4
        end
        misal = fpC1 & lockReg & ((byteReg != {BCW{1'b0}})
              | (~tport & (frameReg != 6'd0)));
        kChar = (curByte == {BCW{1'b0}}) & (curFrame == 6'd0);
        parErr = ^{datS, parS, ctrlReg[`TSI_CTRL_ODD],
                   (tport ? (fpS & ctrlReg[`TSI_CTRL_PFP]) : v5S),
                   (plS & (~tport | ctrlReg[`TSI_CTRL_PPL]))}; // R9
    end

    reg  [5:0] c6;                     // raw 6b sub-block
    reg  [3:0] c4;                     // raw 4b sub-block
    reg        rdMid;                  // disparity after 6b
    reg        alt7;                   // alternate code for y = 7
    reg  [9:0] code;                   // encoded character
    reg        rdNext;                 // disparity after character

    // 8b/10b encoder with comma insertion
    always @* begin
        c6 = kChar ? `TSI_K28_6B : tsi_enc6(datS[4:0]);
        if (rdReg & ((tsi_ones(c6) != `TSI_BAL6)
            | (~kChar & (datS[4:0] == 5'h07)))) begin
            code[9:4] = ~c6;                              // R19
        end else begin
            code[9:4] = c6;
        end
        rdMid = (tsi_ones(c6) != `TSI_BAL6) ? ~rdReg : rdReg;
        alt7 = rdMid ? ((datS[4:0] == 5'h0B) | (datS[4:0] == 5'h0D)
                      | (datS[4:0] == 5'h0E))
                     : ((datS[4:0] == 5'h11) | (datS[4:0] == 5'h12)
                      | (datS[4:0] == 5'h14));
        if (kChar) begin
            c4 = `TSI_K28_4B;
        end else if ((datS[7:5] == 3'h7) & alt7) begin
            c4 = 4'h7;
        end else begin
            c4 = tsi_enc4(datS[7:5]);
        end
        if (rdMid & ((tsi_ones({2'b00, c4}) != `TSI_BAL4)
            | kChar | (datS[7:5] == 3'h3))) begin
            code[3:0] = ~c4;
        end else begin
            code[3:0] = c4;
        end
        rdNext = (tsi_ones({2'b00, c4}) != `TSI_BAL4) ? ~rdMid : rdMid;
    end

    // two-stage synchroniser on every bus input
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1Reg <= 14'h0000;
            sync2Reg <= 14'h0000;
        end else begin
            sync1Reg <= {incomingFramePulse, incomingBusByte,
                         incomingParity, incomingPayloadFlag,
                         incomingPayloadIndicator,
                         incomingTributaryPayload,
                         incomingTributaryAlarm};         // R7 R24
            sync2Reg <= sync1Reg;
        end
    end

    // byte-slot divider: one bus byte per character time
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            divReg <= 4'h0;
        end else if (byteEn) begin
            divReg <= 4'h0;                               // R20 R23
        end else begin
            divReg <= divReg + 4'h1;
        end
    end

    // frame and multiframe counters with flywheel
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            byteReg  <= {BCW{1'b0}};
            frameReg <= 6'd0;
            lockReg  <= 1'b0;
            flyReg   <= 1'b0;
        end else if (byteEn) begin
            if (curByte == BYTE_LAST) begin
                byteReg  <= {BCW{1'b0}};
                frameReg <= (curFrame >= mfLast) ?
                            6'd0 : curFrame + 6'd1;       // R3
            end else begin
                byteReg  <= curByte + 1'b1;
                frameReg <= curFrame;
            end
            if (fpC1) begin
                lockReg <= 1'b1;
                flyReg  <= 1'b0;
            end else if (kChar & lockReg) begin
                flyReg  <= 1'b1;                          // R3
            end
        end
    end

    // serialiser: both links from one shift register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdReg        <= 1'b0;
            shiftReg     <= 10'h000;
            kPendReg     <= 1'b0;
            txWorkP      <= 1'b0;
            txWorkN      <= 1'b1;
            txProtP      <= 1'b0;
            txProtN      <= 1'b1;
            txFramePulse <= 1'b0;
        end else begin
            if (byteEn) begin
                shiftReg <= code;                         // R19
                rdReg    <= rdNext;
                kPendReg <= kChar;
            end else begin
                shiftReg <= {shiftReg[8:0], 1'b0};
            end
            txWorkP      <= shiftReg[9];                  // R26
            txWorkN      <= ~shiftReg[9];
            txProtP      <= shiftReg[9];
            txProtN      <= ~shiftReg[9];
            txFramePulse <= byteEn & kPendReg;            // R21 R22
        end
    end

    // wishbone slave, status flags and parity tally
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
            ctrlReg   <= `TSI_CTRL_RST;
            stickyReg <= `TSI_STICKY_RST;
            pcntReg   <= {`TSI_PCNT_W{1'b0}};
        end else begin
            wb_ack_o <= wbReq;
            // read data; unmapped offsets read zero
            if (wbReq & ~wb_we_i) begin
                case (wb_adr_i)
                    `TSI_ADDR_CTRL: wb_dat_o <= {26'h0, ctrlReg};
                    `TSI_ADDR_STAT: wb_dat_o <= {26'h0, stickyReg,
                                                 flyReg, lockReg};
                    `TSI_ADDR_PCNT: wb_dat_o <= {16'h0, pcntReg};
                    default:        wb_dat_o <= 32'h00000000;
                endcase
            end
            if (wbWr & (wb_adr_i == `TSI_ADDR_CTRL)) begin
                ctrlReg <= wb_dat_i[`TSI_CTRL_W-1:0];
            end
            // sticky flags: write one clears, a new event wins
            stickyReg <= (wbWr & (wb_adr_i == `TSI_ADDR_STAT)) ?
                         stickyReg & ~wb_dat_i[5:2] : stickyReg;
            if (byteEn) begin
                stickyReg <= ((wbWr & (wb_adr_i == `TSI_ADDR_STAT)) ?
                              stickyReg & ~wb_dat_i[5:2] : stickyReg)
                           | {tport & tplS, tport & aisS,
                              misal, parErr};             // R17 R18 R25
            end
            // saturating tally of parity errors, cleared on write
            if (wbWr & (wb_adr_i == `TSI_ADDR_PCNT)) begin
                pcntReg <= {`TSI_PCNT_W{1'b0}};
            end else if (byteEn & parErr & ~&pcntReg) begin
                pcntReg <= pcntReg + 1'b1;                // R25
            end
        end
    end

endmodule
`default_nettype wire

// ===== tsi_ingress_props.sv
// port checks on the ingress serializer
`timescale 1ns/1ps
`default_nettype none
module tsi_ingress_chk #(
    parameter FRAME_BYTES = 9720
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic txWorkP,
    input wire logic txWorkN,
    input wire logic txProtP,
    input wire logic txProtN,
    input wire logic txFramePulse
);
    logic [8:0] bits_reg; // earlier line bits
    int         gap_reg;  // clocks since pulse
    logic       seen_reg; // a pulse went by
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // line history and pulse spacing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bits_reg <= 9'h000;
            gap_reg <= 0;
            seen_reg <= 1'b0;
        end else begin
            bits_reg <= {bits_reg[7:0], txWorkP};
            gap_reg <= txFramePulse ? 0 : gap_reg + 1;
            seen_reg <= seen_reg | txFramePulse;
        end
    end
    chk_links_equal: assert property (txWorkP == txProtP)
        else $error("links differ");
    chk_work_pair: assert property (txWorkN == !txWorkP)
        else $error("work pair");
    chk_prot_pair: assert property (txProtN == !txProtP)
        else $error("protect pair");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    chk_ack_prompt: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_cause: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack idle");
    chk_pulse_comma: assert property (txFramePulse |->
        {bits_reg, txWorkP} == 10'h0FA || {bits_reg, txWorkP} == 10'h305)
        else $error("no comma at pulse");
    chk_pulse_grid: assert property (txFramePulse && seen_reg |->
        (gap_reg + 1) % (FRAME_BYTES * 10) == 0) else $error("pulse off grid");
endmodule
bind tsi_ingress tsi_ingress_chk #(.FRAME_BYTES(FRAME_BYTES)) chk_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .txWorkP(txWorkP), .txWorkN(txWorkN),
    .txProtP(txProtP), .txProtN(txProtN), .txFramePulse(txFramePulse));
`default_nettype wire

// ===== tsi_tb.sv
// self-checking bench for the ingress serializer
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"
module tb;
    localparam int FB = 20;      // short frame
    localparam int MF = FB * 10; // clocks per frame
    logic        clk = 0;        // one clock for both buses
    logic        rst = 0;
    logic        cyc = 0, stb = 0, we = 0, ack;
    logic [7:0]  adr = 0, bb;
    logic [31:0] dat = 0, rdat;
    logic [3:0]  sel = 0;
    logic        transport = 0, noPulse = 0, badReq = 0, flags = 0;
    logic [5:0]  mfLen = 6'h04;
    logic [9:0]  rnd = 0;
    logic        fp, par, pl, ind, tpl, alm, wP, wN, pP, pN, txFp;
    int          seed = 58166;
    int          n_fail = 0;
    int          comparisons = 0;
    always #25 clk = ~clk;
    always @(posedge clk) rnd <= 10'($random(seed));
    tsi_ingress #(.FRAME_BYTES(FB)) tsi_ingress_inst (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_ack_o(ack), .wb_dat_o(rdat), .incomingFramePulse(fp),
        .incomingBusByte(bb), .incomingParity(par),
        .incomingPayloadFlag(pl), .incomingPayloadIndicator(ind),
        .incomingTributaryPayload(tpl), .incomingTributaryAlarm(alm),
        .txWorkP(wP), .txWorkN(wN), .txProtP(pP), .txProtN(pN),
        .txFramePulse(txFp));
    tsi_bus_model #(.FRAME_BYTES(FB)) tsi_bus_model_inst (
        .clk(clk), .rst(rst), .transport(transport), .mfLen(mfLen),
        .noPulse(noPulse), .badReq(badReq), .flagsIn(flags),
        .rndIn(rnd), .framePulse(fp), .busByte(bb), .parity(par),
        .payloadFlag(pl), .payloadInd(ind), .tribPayload(tpl),
        .tribAlarm(alm));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        n_fail++;
        $display("BAD %0t wait ran out", $time);
        print_verdict();
    endtask
    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (i == 50) hang();
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hF, q);
        check(q & m, e);
    endtask
    // clocks between two transmit frame pulses
    task automatic gap(output int g);
        int i;
        for (i = 0; i < 20000 && txFp !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        for (g = 1; g < 20000 && txFp !== 1'b1; g++) @(posedge clk);
        if (i == 20000 || g == 20000) hang();
    endtask
    initial begin
        logic [31:0] k, q;
        int g;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, byte lane gate, unmapped place
        rd(`TSI_ADDR_CTRL, 32'h3F, 32'h0);
        rd(`TSI_ADDR_PCNT, 32'hFFFF, 32'h0);
        rd(8'h0C, 32'hFFFFFFFF, 32'h0);
        k = $random(seed) & 32'h3F;
        wr(`TSI_ADDR_CTRL, k);
        wb(1'b1, `TSI_ADDR_CTRL, ~k, 4'hE, q);
        wr(8'h0C, 32'hFF);
        rd(`TSI_ADDR_CTRL, 32'h3F, k);
        wr(`TSI_ADDR_CTRL, 32'h0);
        // tributary mode multiframe
        gap(g);
        gap(g);
        check(g, 4 * MF);
        rd(`TSI_ADDR_STAT, 32'h1, 32'h1);
        // spoiled parity is counted and flagged
        wr(`TSI_ADDR_STAT, 32'h3F);
        wr(`TSI_ADDR_PCNT, 32'h0);
        repeat (3) begin
            badReq <= 1'b1;
            @(posedge clk);
            badReq <= 1'b0;
            repeat (30) @(posedge clk);
        end
        rd(`TSI_ADDR_PCNT, 32'hFFFF, 32'h3);
        rd(`TSI_ADDR_STAT, 32'h4, 32'h4);
        wr(`TSI_ADDR_STAT, 32'h4);
        rd(`TSI_ADDR_STAT, 32'h4, 32'h0);
        // tributary flags ignored, then seen in transport mode
        flags <= 1'b1;
        repeat (30) @(posedge clk);
        wr(`TSI_ADDR_STAT, 32'h30);
        repeat (30) @(posedge clk);
        rd(`TSI_ADDR_STAT, 32'h30, 32'h0);
        transport <= 1'b1;
        wr(`TSI_ADDR_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        wr(`TSI_ADDR_STAT, 32'h3F);
        wr(`TSI_ADDR_PCNT, 32'h0);
        repeat (30) @(posedge clk);
        rd(`TSI_ADDR_STAT, 32'h30, 32'h30);
        rd(`TSI_ADDR_PCNT, 32'hFFFF, 32'h0);
        gap(g);
        check(g, 4 * MF);
        rd(`TSI_ADDR_STAT, 32'h8, 32'h0);
        // pulse withheld: flywheel keeps the grid
        noPulse <= 1'b1;
        gap(g);
        check(g, 4 * MF);
        rd(`TSI_ADDR_STAT, 32'h2, 32'h2);
        // signaling multiframe of 48 frames
        noPulse <= 1'b0;
        transport <= 1'b0;
        mfLen <= 6'd48;
        wr(`TSI_ADDR_CTRL, 32'h2);
        gap(g);
        gap(g);
        check(g, 48 * MF);
        print_verdict();
    end
endmodule
`default_nettype wire
